// File: dcad_bank.sv
`timescale 1ns/1ps
module dcad_bank #(
  parameter int ROW_W = 18
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic open_in,
  input wire logic close_in,
  input wire logic [ROW_W-1:0] row_in,
  output logic open_out,
  output logic [ROW_W-1:0] row_out
);

  // ==========================================================
  // open flag
  // activate wins if both arrive, which only a broken controller does
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      open_out <= 1'b0;
    end else if (open_in) begin
      open_out <= 1'b1;
    end else if (close_in) begin
      open_out <= 1'b0;
    end
  end

  // ==========================================================
  // open row
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      row_out <= '0;
    end else if (open_in) begin
      row_out <= row_in;
    end
  end

endmodule

// File: dcad_ctrl.sv
`timescale 1ns/1ps
// ==========================================================
// controller model on the command bus
module dcad_ctrl (
  input wire logic clk_in,
  output logic cs_b_out = 1'b1,
  output logic act_b_out = 1'b1,
  output logic [2:0] rcw_out = 3'h7,
  output logic [14:0] ad_out = 15'h0000,
  output logic [3:0] bb_out = 4'h0,
  output logic [2:0] cid_out = 3'h1,
  output logic cke_out = 1'b1
);
  logic ke = 1'b1;
  logic [2:0] cid = 3'h1;
  // fields change together after an edge, held to the next
  task automatic cmd(input logic cs, input logic act,
      input logic [2:0] rcw, input logic [14:0] ad, input logic [3:0] bb);
    @(posedge clk_in);
    cs_b_out <= cs;
    act_b_out <= act;
    rcw_out <= rcw;
    ad_out <= ad;
    bb_out <= bb;
    cid_out <= cid;
    // reads and writes never go out with cke low
    cke_out <= ke | (~cs & act & (rcw[2:1] == 2'b10));
  endtask
  // released lines show the inverse, so a stale value never passes
  task automatic idle();
    @(posedge clk_in);
    cs_b_out <= 1'b1;
    act_b_out <= 1'b1;
    rcw_out <= ~rcw_out;
    ad_out <= ~ad_out;
    bb_out <= ~bb_out;
    cke_out <= ke;
  endtask
endmodule

// File: dcad_decode.sv
`timescale 1ns/1ps
module dcad_decode #(
  parameter int DEV_WIDTH = dcad_pkg::ORG_X4,
  parameter int STACK_H = dcad_pkg::STACK_1H,
  parameter int DIE_ID = 0
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cs_b_in,
  input wire logic act_b_in,
  input wire logic ras_b_in,
  input wire logic cas_b_in,
  input wire logic we_b_in,
  input wire logic [dcad_pkg::LOW_ADDR_W-1:0] addr_in,
  input wire logic a17_in,
  input wire logic [dcad_pkg::BG_W-1:0] bg_in,
  input wire logic [dcad_pkg::BA_W-1:0] ba_in,
  input wire logic [dcad_pkg::CID_W-1:0] chip_id_in,
  input wire logic cke_in,
  output logic cmd_valid_out,
  output dcad_pkg::dcad_cmd_t cmd_out,
  output logic [dcad_pkg::ROW_W-1:0] row_addr_out,
  output logic [dcad_pkg::COL_W-1:0] col_addr_out,
  output logic [dcad_pkg::BG_W-1:0] bg_out,
  output logic [dcad_pkg::BA_W-1:0] ba_out,
  output logic auto_pre_out,
  output logic burst_chop_out,
  output logic pre_all_out,
  output logic [dcad_pkg::MR_SEL_W-1:0] mr_sel_out,
  output logic [dcad_pkg::OP_W-1:0] mr_opcode_out,
  output logic [dcad_pkg::ROW_W-1:0] access_row_out,
  output logic [dcad_pkg::BANK_N-1:0] bank_open_out,
  output logic int_clk_en_out,
  output logic out_drv_en_out,
  output logic cmd_ibuf_en_out,
  output logic clk_ibuf_en_out,
  output logic power_down_out,
  output logic active_pd_out,
  output logic self_refresh_out
);

  // ==========================================================
  // elaboration checks
  generate
    if (DEV_WIDTH != dcad_pkg::ORG_X4 && DEV_WIDTH != dcad_pkg::ORG_X8 &&
        DEV_WIDTH != dcad_pkg::ORG_X16) begin : g_bad_width
      $error("dcad_decode: DEV_WIDTH must be 4, 8 or 16");
    end
    if (STACK_H != dcad_pkg::STACK_1H && STACK_H != dcad_pkg::STACK_2H &&
        STACK_H != dcad_pkg::STACK_4H && STACK_H != dcad_pkg::STACK_8H)
    begin : g_bad_stack
      $error("dcad_decode: STACK_H must be 1, 2, 4 or 8");
    end
    if (DIE_ID < 0 || DIE_ID >= STACK_H) begin : g_bad_die
      $error("dcad_decode: DIE_ID outside the stack");
    end
    if (DEV_WIDTH == dcad_pkg::ORG_X16 && STACK_H != dcad_pkg::STACK_1H)
    begin : g_bad_x16_stack
      $error("dcad_decode: x16 parts cannot be stacked by chip id");
    end
  endgenerate

  // ==========================================================
  // organisation constants
  localparam int CID_USE = (STACK_H == dcad_pkg::STACK_8H) ? 3 :
                           (STACK_H == dcad_pkg::STACK_4H) ? 2 :
                           (STACK_H == dcad_pkg::STACK_2H) ? 1 : 0;
  localparam logic [dcad_pkg::CID_W-1:0] CID_MASK =
    dcad_pkg::CID_W'((1 << CID_USE) - 1);
  localparam logic [dcad_pkg::CID_W-1:0] CID_SELF =
    dcad_pkg::CID_W'(DIE_ID);
  localparam logic USE_A17 = (DEV_WIDTH == dcad_pkg::ORG_X4);
  localparam logic USE_BG1 = (DEV_WIDTH != dcad_pkg::ORG_X16);

  // ==========================================================
  // pin level conditioning
  logic a17_eff;
  logic [dcad_pkg::BG_W-1:0] bg_eff;
  logic die_match;
  logic [dcad_pkg::ROW_W-1:0] row_full;
  logic [dcad_pkg::BANK_IDX_W-1:0] bank_idx;
  logic [2:0] rcw;

  assign a17_eff = USE_A17 & a17_in;
  assign bg_eff = {USE_BG1 & bg_in[1], bg_in[0]};
  // unstacked parts ignore the chip id pins entirely
  assign die_match =
    ((chip_id_in & CID_MASK) == (CID_SELF & CID_MASK));
  // the three command pins double as row bits under activate and as opcode bits under a mode register set
  assign row_full = {a17_eff, ras_b_in, cas_b_in, we_b_in, addr_in};
  assign bank_idx = {bg_eff, ba_in};
  assign rcw = {ras_b_in, cas_b_in, we_b_in};

  // ==========================================================
  // power state registers
  logic cke_q;
  logic pd_q;
  logic apd_q;
  logic sr_q;
  logic clk_ibuf_q;
  logic cmd_ibuf_q;
  logic any_open;

  // ==========================================================
  // command qualification
  logic addressed;
  logic cmd_live;
  logic cke_fall;
  logic sr_enter;
  logic pd_enter;
  logic pd_d;
  logic low_pwr_d;
  dcad_pkg::dcad_cmd_t cmd_d;

  // chip select low plus die match; a high select masks all codes
  assign addressed = !cs_b_in && die_match;
  // commands only while enable was high on both edges and buffers run
  assign cmd_live = addressed && cke_q && cke_in && cmd_ibuf_q &&
                    !pd_q && !sr_q;
  assign cke_fall = cke_q && !cke_in && !pd_q && !sr_q;
  // self refresh needs all banks idle; otherwise fall into power-down
  assign sr_enter = cke_fall && addressed && act_b_in &&
                    (rcw == dcad_pkg::RCW_REF) && !any_open;
  assign pd_enter = cke_fall && !sr_enter;
  assign pd_d = pd_q ? !cke_in : pd_enter;
  assign low_pwr_d = pd_d || sr_enter || (sr_q && !cke_in);

  // ==========================================================
  // command decode
  always_comb begin
    cmd_d = dcad_pkg::DCAD_CMD_NONE;
    if (cmd_live) begin
      if (!act_b_in) begin
        cmd_d = dcad_pkg::DCAD_CMD_ACT;
      end else begin
        case (rcw)
          dcad_pkg::RCW_MRS: begin
            cmd_d = dcad_pkg::DCAD_CMD_MRS;
          end
          dcad_pkg::RCW_REF: begin
            cmd_d = dcad_pkg::DCAD_CMD_REF;
          end
          dcad_pkg::RCW_PRE: begin
            // bit 10 high widens the precharge to every bank
            cmd_d = addr_in[dcad_pkg::AP_BIT] ? dcad_pkg::DCAD_CMD_PREA :
                    dcad_pkg::DCAD_CMD_PRE;
          end
          dcad_pkg::RCW_RFU: begin
            cmd_d = dcad_pkg::DCAD_CMD_RFU;
          end
          dcad_pkg::RCW_WR: begin
            cmd_d = dcad_pkg::DCAD_CMD_WR;
          end
          dcad_pkg::RCW_RD: begin
            cmd_d = dcad_pkg::DCAD_CMD_RD;
          end
          dcad_pkg::RCW_ZQ: begin
            cmd_d = dcad_pkg::DCAD_CMD_ZQ;
          end
          dcad_pkg::RCW_NOP: begin
            cmd_d = dcad_pkg::DCAD_CMD_NONE;
          end
          default: begin
            cmd_d = dcad_pkg::DCAD_CMD_NONE;
          end
        endcase
      end
    end
  end

  logic is_rdwr;
  assign is_rdwr = (cmd_d == dcad_pkg::DCAD_CMD_RD) ||
                   (cmd_d == dcad_pkg::DCAD_CMD_WR);

  // ==========================================================
  // bank trackers
  logic [dcad_pkg::BANK_N-1:0] bank_set;
  logic [dcad_pkg::BANK_N-1:0] bank_clr;
  logic [dcad_pkg::ROW_W-1:0] bank_row [dcad_pkg::BANK_N];

  genvar gi;
  generate
    for (gi = 0; gi < dcad_pkg::BANK_N; gi++) begin : g_bank
      logic hit;
      assign hit = (bank_idx == dcad_pkg::BANK_IDX_W'(gi));
      assign bank_set[gi] = hit && (cmd_d == dcad_pkg::DCAD_CMD_ACT);
      // auto precharge is modelled as closing right after the access
      assign bank_clr[gi] = (cmd_d == dcad_pkg::DCAD_CMD_PREA) ||
                            (hit && cmd_d == dcad_pkg::DCAD_CMD_PRE) ||
                            (hit && is_rdwr &&
                             addr_in[dcad_pkg::AP_BIT]);
      dcad_bank #(
        .ROW_W(dcad_pkg::ROW_W)
      ) u_bank (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .open_in(bank_set[gi]),
        .close_in(bank_clr[gi]),
        .row_in(row_full),
        .open_out(bank_open_out[gi]),
        .row_out(bank_row[gi])
      );
    end
  endgenerate

  assign any_open = |bank_open_out;

  // ==========================================================
  // command strobe
  // every command pin is registered on the single rising clock edge; cke also clears self refresh asynchronously
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmd_valid_out <= 1'b0;
      cmd_out <= dcad_pkg::DCAD_CMD_NONE;
    end else begin
      cmd_valid_out <= (cmd_d != dcad_pkg::DCAD_CMD_NONE);
      cmd_out <= cmd_d;
    end
  end

  // ==========================================================
  // target bank and group
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bg_out <= '0;
      ba_out <= '0;
    end else if (cmd_d != dcad_pkg::DCAD_CMD_NONE) begin
      bg_out <= bg_eff;
      ba_out <= ba_in;
    end
  end

  // ==========================================================
  // row and column addressing
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      row_addr_out <= dcad_pkg::ROW_RST;
      col_addr_out <= dcad_pkg::COL_RST;
      access_row_out <= dcad_pkg::ROW_RST;
    end else begin
      if (cmd_d == dcad_pkg::DCAD_CMD_ACT) begin
        row_addr_out <= row_full;
      end
      if (is_rdwr) begin
        col_addr_out <= addr_in[dcad_pkg::COL_W-1:0];
        access_row_out <= bank_row[bank_idx];
      end
    end
  end

  // ==========================================================
  // read/write and precharge qualifiers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      auto_pre_out <= 1'b0;
      burst_chop_out <= 1'b0;
      pre_all_out <= 1'b0;
    end else begin
      if (is_rdwr) begin
        auto_pre_out <= addr_in[dcad_pkg::AP_BIT];
        burst_chop_out <= !addr_in[dcad_pkg::BC_BIT];
      end
      if (cmd_d == dcad_pkg::DCAD_CMD_PRE ||
          cmd_d == dcad_pkg::DCAD_CMD_PREA) begin
        pre_all_out <= addr_in[dcad_pkg::AP_BIT];
      end
    end
  end

  // ==========================================================
  // mode register access
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mr_sel_out <= '0;
      mr_opcode_out <= '0;
    end else if (cmd_d == dcad_pkg::DCAD_CMD_MRS) begin
      mr_sel_out <= {bg_eff, ba_in};
      mr_opcode_out <= row_full;
    end
  end

  // ==========================================================
  // power-down tracking
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cke_q <= 1'b0;
      pd_q <= 1'b0;
      apd_q <= 1'b0;
    end else begin
      cke_q <= cke_in;
      pd_q <= pd_d;
      if (pd_enter) begin
        apd_q <= any_open;
      end else if (!pd_d) begin
        apd_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // self refresh
  // enable high clears it at once; no clock edge is needed to leave,
  // at the cost of enable acting as an asynchronous control
  always_ff @(posedge clk_in or negedge rst_b_in or posedge cke_in) begin
    if (!rst_b_in) begin
      sr_q <= 1'b0;
      clk_ibuf_q <= 1'b1;
    end else if (cke_in) begin
      sr_q <= 1'b0;
      clk_ibuf_q <= 1'b1;
    end else if (sr_enter) begin
      sr_q <= 1'b1;
      clk_ibuf_q <= 1'b0;
    end
  end

  // ==========================================================
  // buffers, clocks and drivers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmd_ibuf_q <= 1'b1;
      int_clk_en_out <= 1'b0;
      out_drv_en_out <= 1'b0;
    end else begin
      // power-down and self refresh both shut the command buffers
      cmd_ibuf_q <= !low_pwr_d;
      int_clk_en_out <= cke_in;
      out_drv_en_out <= cke_in;
    end
  end

  assign cmd_ibuf_en_out = cmd_ibuf_q;
  assign clk_ibuf_en_out = clk_ibuf_q;
  assign power_down_out = pd_q;
  assign active_pd_out = apd_q;
  assign self_refresh_out = sr_q;

endmodule

// File: dcad_decode_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// decode checker, top ports only
module dcad_chk #(
  parameter int DEV_WIDTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cs_b_in,
  input wire logic ras_b_in,
  input wire logic cas_b_in,
  input wire logic we_b_in,
  input wire logic [13:0] addr_in,
  input wire logic a17_in,
  input wire logic [1:0] bg_in,
  input wire logic [1:0] ba_in,
  input wire logic cke_in,
  input wire logic cmd_valid_out,
  input wire dcad_pkg::dcad_cmd_t cmd_out,
  input wire logic [17:0] row_addr_out,
  input wire logic [9:0] col_addr_out,
  input wire logic [1:0] bg_out,
  input wire logic [1:0] ba_out,
  input wire logic auto_pre_out,
  input wire logic burst_chop_out,
  input wire logic pre_all_out,
  input wire logic [3:0] mr_sel_out,
  input wire logic [17:0] mr_opcode_out,
  input wire logic [15:0] bank_open_out,
  input wire logic int_clk_en_out,
  input wire logic out_drv_en_out,
  input wire logic cmd_ibuf_en_out,
  input wire logic clk_ibuf_en_out,
  input wire logic power_down_out,
  input wire logic active_pd_out,
  input wire logic self_refresh_out
);
  logic [13:0] addr_q;
  always_ff @(posedge clk_in) addr_q <= addr_in;
  wire v_act = cmd_valid_out && cmd_out == dcad_pkg::DCAD_CMD_ACT;
  wire v_mrs = cmd_valid_out && cmd_out == dcad_pkg::DCAD_CMD_MRS;
  wire v_rw = cmd_valid_out && (cmd_out == dcad_pkg::DCAD_CMD_RD ||
    cmd_out == dcad_pkg::DCAD_CMD_WR);
  wire v_pre = cmd_valid_out && (cmd_out == dcad_pkg::DCAD_CMD_PRE ||
    cmd_out == dcad_pkg::DCAD_CMD_PREA);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ==========================================================
  // command fields
  AST_ACT_ROW: assert property (v_act |-> row_addr_out ==
    {$past(a17_in) & (DEV_WIDTH == 4), $past(ras_b_in), $past(cas_b_in),
    $past(we_b_in), $past(addr_in)}) else $error("act row wrong");
  AST_ACT_BANK: assert property (v_act |->
    bg_out == ($past(bg_in) & {DEV_WIDTH != 16, 1'b1}) &&
    ba_out == $past(ba_in) && bank_open_out[{bg_out, ba_out}])
    else $error("act bank wrong");
  AST_RW_COL: assert property (v_rw |->
    col_addr_out == addr_q[9:0] && auto_pre_out == addr_q[10] &&
    burst_chop_out == !addr_q[12]) else $error("rd/wr fields wrong");
  AST_PRE_SEL: assert property (v_pre |->
    pre_all_out == addr_q[10] &&
    (cmd_out == dcad_pkg::DCAD_CMD_PREA) == addr_q[10] &&
    ba_out == $past(ba_in)) else $error("precharge fields wrong");
  AST_MRS_OP: assert property (v_mrs |->
    mr_opcode_out[13:0] == addr_q &&
    mr_sel_out == {$past(bg_in) & {DEV_WIDTH != 16, 1'b1}, $past(ba_in)})
    else $error("mrs wrong");
  AST_CS_MASK: assert property ($past(cs_b_in) |->
    !cmd_valid_out) else $error("command with cs high");
  // ==========================================================
  // clock enable and low power
  AST_CKE_GATE: assert property (!$past(cke_in) |-> !cmd_valid_out &&
    !int_clk_en_out && !out_drv_en_out) else $error("cke gate wrong");
  AST_LP_ENTRY: assert property (int_clk_en_out && !cke_in &&
    !power_down_out && !self_refresh_out |=>
    (power_down_out != self_refresh_out) && !cmd_ibuf_en_out)
    else $error("no low power entry");
  AST_APD: assert property (power_down_out |->
    active_pd_out == (bank_open_out != 16'h0000)) else $error("apd wrong");
  AST_PD_BUF: assert property (power_down_out |-> !cmd_ibuf_en_out &&
    clk_ibuf_en_out && !cmd_valid_out) else $error("pd buffers wrong");
  AST_SR_BUF: assert property (self_refresh_out |->
    !clk_ibuf_en_out && !cmd_ibuf_en_out) else $error("sr buffers wrong");
  AST_SR_EXIT: assert property (cke_in |-> !self_refresh_out)
    else $error("sr exit not async");
endmodule
bind dcad_decode dcad_chk #(.DEV_WIDTH(DEV_WIDTH)) i_dcad_chk (.clk_in,
  .rst_b_in, .cs_b_in, .ras_b_in, .cas_b_in, .we_b_in, .addr_in, .a17_in,
  .bg_in, .ba_in, .cke_in, .cmd_valid_out, .cmd_out, .row_addr_out,
  .col_addr_out, .bg_out, .ba_out, .auto_pre_out, .burst_chop_out,
  .pre_all_out, .mr_sel_out, .mr_opcode_out, .bank_open_out,
  .int_clk_en_out, .out_drv_en_out, .cmd_ibuf_en_out, .clk_ibuf_en_out,
  .power_down_out, .active_pd_out, .self_refresh_out);

// File: dcad_pkg.sv
package dcad_pkg;

  // ==========================================================
  // field widths
  localparam int ROW_W = 18;
  localparam int COL_W = 10;
  localparam int LOW_ADDR_W = 14;
  localparam int BG_W = 2;
  localparam int BA_W = 2;
  localparam int CID_W = 3;
  localparam int MR_SEL_W = BG_W + BA_W;
  localparam int OP_W = ROW_W;
  localparam int BANK_N = 16;
  localparam int BANK_IDX_W = BG_W + BA_W;

  // ==========================================================
  // address bit positions with a second meaning
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int A17_BIT = 17;
  localparam int A16_BIT = 16;
  localparam int A15_BIT = 15;
  localparam int A14_BIT = 14;

  // ==========================================================
  // organisation and stacking defaults
  localparam int ORG_X4 = 4;
  localparam int ORG_X8 = 8;
  localparam int ORG_X16 = 16;
  localparam int STACK_1H = 1;
  localparam int STACK_2H = 2;
  localparam int STACK_4H = 4;
  localparam int STACK_8H = 8;

  // ==========================================================
  // ras/cas/we codes when the activate input is high
  localparam logic [2:0] RCW_MRS = 3'h0;
  localparam logic [2:0] RCW_REF = 3'h1;
  localparam logic [2:0] RCW_PRE = 3'h2;
  localparam logic [2:0] RCW_RFU = 3'h3;
  localparam logic [2:0] RCW_WR = 3'h4;
  localparam logic [2:0] RCW_RD = 3'h5;
  localparam logic [2:0] RCW_ZQ = 3'h6;
  localparam logic [2:0] RCW_NOP = 3'h7;

  // ==========================================================
  // reset values
  localparam logic [ROW_W-1:0] ROW_RST = 18'h0_0000;
  localparam logic [COL_W-1:0] COL_RST = 10'h000;

  typedef enum logic [3:0] {
    DCAD_CMD_NONE,
    DCAD_CMD_ACT,
    DCAD_CMD_RD,
    DCAD_CMD_WR,
    DCAD_CMD_PRE,
    DCAD_CMD_PREA,
    DCAD_CMD_REF,
    DCAD_CMD_MRS,
    DCAD_CMD_ZQ,
    DCAD_CMD_RFU
  } dcad_cmd_t;

endpackage

// File: testbench.sv
`timescale 1ns/1ps
// ==========================================================
// top bench
module testbench;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cs, act, cke, v, ap, bc, pa, ice, ode, cib, kib, pd, apd, sr;
  logic [2:0] rcw, cid;
  logic [14:0] ad;
  logic [3:0] bb, ms;
  logic [17:0] ra, mo, ar;
  logic [9:0] ca;
  logic [1:0] bgo, bao;
  logic [15:0] bo;
  dcad_pkg::dcad_cmd_t cm;
  int fails = 0;
  int compares = 0;
  always #25 clk_in = ~clk_in;
  dcad_ctrl i_dcad_ctrl (.clk_in(clk_in), .cs_b_out(cs), .act_b_out(act),
    .rcw_out(rcw), .ad_out(ad), .bb_out(bb), .cid_out(cid), .cke_out(cke));
  // two-die stack, this die answers to id 1
  dcad_decode #(.DEV_WIDTH(4), .STACK_H(2), .DIE_ID(1)) i_dcad_decode (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .cs_b_in(cs), .act_b_in(act),
    .ras_b_in(rcw[2]), .cas_b_in(rcw[1]), .we_b_in(rcw[0]),
    .addr_in(ad[13:0]), .a17_in(ad[14]), .bg_in(bb[3:2]), .ba_in(bb[1:0]),
    .chip_id_in(cid), .cke_in(cke), .cmd_valid_out(v), .cmd_out(cm),
    .row_addr_out(ra), .col_addr_out(ca), .bg_out(bgo), .ba_out(bao),
    .auto_pre_out(ap), .burst_chop_out(bc), .pre_all_out(pa),
    .mr_sel_out(ms), .mr_opcode_out(mo), .access_row_out(ar),
    .bank_open_out(bo), .int_clk_en_out(ice), .out_drv_en_out(ode),
    .cmd_ibuf_en_out(cib), .clk_ibuf_en_out(kib), .power_down_out(pd),
    .active_pd_out(apd), .self_refresh_out(sr));
  // wide enough for the longest packed compare, so nothing is cut off
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic a, input logic [2:0] r,
      input logic [14:0] d, input logic [3:0] b);
    i_dcad_ctrl.cmd(1'b0, a, r, d, b);
  endtask
  task automatic idl(input int n);
    repeat (n) i_dcad_ctrl.idle();
    #1;
  endtask
  task automatic end_of_test();
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_act();
    cmd(1'b0, 3'h5, 15'h6a5c, 4'hb);
    idl(1);
    chk(cm, dcad_pkg::DCAD_CMD_ACT);
    chk(ra, 18'h3_6a5c);
    chk({bgo, bao, bo}, 20'hb_0800);
    idl(1);
    chk(v, 1'b0);
  endtask
  // back-to-back chopped read with auto precharge, then unchopped write
  task automatic t_rw();
    cmd(1'b1, 3'h5, 15'h05a3, 4'hb);
    cmd(1'b1, 3'h4, 15'h10c7, 4'hb);
    #1;
    chk({cm, ca, ap, bc}, {4'h2, 10'h1a3, 2'h3});
    chk(ar, 18'h3_6a5c);
    chk(bo, 16'h0000);
    idl(1);
    chk({cm, ca, ap, bc}, {4'h3, 10'h0c7, 2'h0});
  endtask
  task automatic t_pre();
    cmd(1'b0, 3'h0, 15'h0001, 4'h6);
    cmd(1'b0, 3'h0, 15'h0002, 4'h9);
    cmd(1'b1, 3'h2, 15'h0000, 4'h6);
    idl(1);
    chk({cm, pa, bo}, {4'h4, 1'b0, 16'h0200});
    cmd(1'b1, 3'h2, 15'h0400, 4'h0);
    idl(1);
    chk({cm, pa, bo}, {4'h5, 1'b1, 16'h0000});
  endtask
  task automatic t_mrs();
    cmd(1'b1, 3'h0, 15'h1234, 4'h6);
    idl(1);
    chk(cm, dcad_pkg::DCAD_CMD_MRS);
    chk(mo, 18'h0_1234);
    chk(ms, 4'h6);
  endtask
  // every code of the command pins
  task automatic t_codes();
    logic [3:0] exp [8] = '{4'h7, 4'h6, 4'h4, 4'h9, 4'h3, 4'h2, 4'h8, 4'h0};
    for (int r = 0; r < 8; r++) begin
      cmd(1'b1, r[2:0], 15'h0000, 4'h0);
      idl(1);
      chk({v, cm}, {r != 7, exp[r]});
    end
  endtask
  task automatic t_mask();
    i_dcad_ctrl.cmd(1'b1, 1'b0, 3'h0, 15'h0001, 4'h1);
    idl(1);
    chk({v, bo}, 17'h0_0000);
    i_dcad_ctrl.cid = 3'h0;
    cmd(1'b0, 3'h0, 15'h0001, 4'h1);
    idl(1);
    chk({v, bo}, 17'h0_0000);
    i_dcad_ctrl.cid = 3'h1;
  endtask
  // open row, drop cke, try a precharge that must be ignored
  task automatic t_pd();
    cmd(1'b0, 3'h0, 15'h0003, 4'h3);
    i_dcad_ctrl.ke = 1'b0;
    idl(2);
    chk({pd, apd, ice, ode}, 4'hc);
    chk({cib, kib}, 2'h1);
    cmd(1'b1, 3'h2, 15'h0400, 4'h0);
    idl(1);
    chk({v, bo}, 17'h0_0008);
    i_dcad_ctrl.ke = 1'b1;
    idl(2);
    chk({pd, cib}, 2'h1);
    cmd(1'b1, 3'h2, 15'h0400, 4'h0);
    idl(1);
    chk(bo, 16'h0000);
    // all banks idle now, so the drop is a precharge power-down
    i_dcad_ctrl.ke = 1'b0;
    idl(2);
    chk({pd, apd, cib}, 3'h4);
    i_dcad_ctrl.ke = 1'b1;
    idl(2);
    chk({pd, cib}, 2'h1);
  endtask
  // refresh with cke falling, leave without a clock edge
  task automatic t_sr();
    i_dcad_ctrl.ke = 1'b0;
    cmd(1'b1, 3'h1, 15'h0000, 4'h0);
    idl(1);
    chk({sr, pd, kib, cib}, 4'h8);
    i_dcad_ctrl.ke = 1'b1;
    idl(1);
    chk({sr, kib}, 2'h1);
    idl(2);
    chk(cib, 1'b1);
  endtask
  initial begin
    repeat (3000) @(posedge clk_in);
    fails++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    idl(2);
    t_act();
    t_rw();
    t_pre();
    t_mrs();
    t_codes();
    t_mask();
    t_pd();
    t_sr();
    end_of_test();
  end
endmodule
